/* design/wdt_rst_defs.vh */
`ifndef WDT_RST_DEFS_VH
`define WDT_RST_DEFS_VH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define CLK_MHZ 200
`define SLOW_OSC_HZ 32000
`define SLOW_DIV_CYC (`CLK_MHZ * 1000000 / `SLOW_OSC_HZ)
`define SOFT_RESET_NS 5000
`define LV_DEBOUNCE_NS 2000
`define NS_TO_CYC_UP(ns) (((ns) * `CLK_MHZ + 999) / 1000)

// ----------------------------------------
// register indices
// ----------------------------------------
`define IDX_WDT_CTRL 2'h0
`define IDX_RST_CTRL 2'h1
`define IDX_LV_LEVEL 2'h2
`define IDX_STATUS 2'h3

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define WDT_CTRL_RST 8'h53
`define LV_LEVEL_RST 8'h55
`define KEY_OK_A 5'h15
`define KEY_OK_B 5'h0A
`define LV_CODE_A 8'h55
`define LV_CODE_B 8'h33
`define LV_CODE_C 8'h99
`define LV_CODE_D 8'hAA

// ----------------------------------------
// field positions
// ----------------------------------------
`define KEY_HI 7
`define KEY_LO 3
`define SEL_HI 2
`define SEL_LO 0
`define RC_SYSCLK 7
`define RC_FOSC_HI 5
`define RC_FOSC_LO 4
`define RC_LOWVOLT_RESET_FLAG 2
`define RC_LRF 1
`define RC_WRF 0
`define ST_PDF 0
`define ST_TO 1

// ----------------------------------------
// watchdog terminal counts
// ----------------------------------------
`define WDT_W 18
`define WDT_TC0 18'h000FF
`define WDT_TC1 18'h003FF
`define WDT_TC2 18'h00FFF
`define WDT_TC3 18'h03FFF
`define WDT_TC4 18'h07FFF
`define WDT_TC5 18'h0FFFF
`define WDT_TC6 18'h1FFFF
`define WDT_TC7 18'h3FFFF

`endif

/* design/hold_timer.v */
`timescale 1ns/1ps
// ----------------------------------------
// fires one pulse once hold_i has stood for n cycles
// ----------------------------------------
module hold_timer #(
  parameter N = 1,
  parameter W = 16
) (
  input wire core_clk_i,
  input wire resetn_i,
  input wire clr_i,
  input wire hold_i,
  output reg fire_o
);
  localparam integer LAST_I = N - 1;
  localparam [W-1:0] LAST = LAST_I[W-1:0];
  reg [W-1:0] cnt_q;
  reg done_q;

  // saturates after firing so a lasting level fires only once
  always @(posedge core_clk_i) begin
    if (!resetn_i || clr_i || !hold_i) begin
      cnt_q <= {W{1'b0}};
      done_q <= 1'b0;
      fire_o <= 1'b0;
    end else begin
      fire_o <= (cnt_q == LAST) && !done_q;
      if (cnt_q == LAST) begin
        done_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // hold_timer

/* design/watchdog_reset_ctrl.v */
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "wdt_rst_defs.vh"
module watchdog_reset_ctrl #(
  parameter SLOW_DIV = `SLOW_DIV_CYC,
  parameter SOFT_DLY_CYC = `NS_TO_CYC_UP(`SOFT_RESET_NS),
  parameter LV_DEB_CYC = `NS_TO_CYC_UP(`LV_DEBOUNCE_NS),
  parameter CNT_W = 16
) (
  input wire core_clk_i,
  input wire resetn_i,
  input wire [1:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire halt_exec_i,
  input wire wdt_clear_exec_i,
  input wire wake_i,
  input wire lowvolt_detect_i,
  output reg sys_reset_o,
  output reg pc_sp_reset_o,
  output reg port_init_o,
  output reg asleep_o,
  output reg [7:0] lowvolt_level_o,
  output reg idle_sysclk_keep_o,
  output reg [1:0] fast_osc_freq_select_o
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function key_ok;
    input [4:0] key;
    begin
      key_ok = (key == `KEY_OK_A) || (key == `KEY_OK_B);
    end
  endfunction

  function lv_ok;
    input [7:0] code;
    begin
      lv_ok = (code == `LV_CODE_A) || (code == `LV_CODE_B) ||
              (code == `LV_CODE_C) || (code == `LV_CODE_D);
    end
  endfunction

  function [`WDT_W-1:0] term_cnt;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: term_cnt = `WDT_TC0;
        3'h1: term_cnt = `WDT_TC1;
        3'h2: term_cnt = `WDT_TC2;
        3'h3: term_cnt = `WDT_TC3;
        3'h4: term_cnt = `WDT_TC4;
        3'h5: term_cnt = `WDT_TC5;
        3'h6: term_cnt = `WDT_TC6;
        default: term_cnt = `WDT_TC7;
      endcase
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  localparam integer DIV_LAST_I = SLOW_DIV - 1;
  localparam [CNT_W-1:0] DIV_LAST = DIV_LAST_I[CNT_W-1:0];
  reg [CNT_W-1:0] div_q;
  reg tick_q;
  reg [`WDT_W-1:0] wdt_cnt_q;
  reg [7:0] wdt_ctrl_q;
  reg [7:0] lv_level_q;
  reg wrf_q;
  reg lrf_q;
  reg lowvolt_reset_flag_q;
  reg to_q;
  reg pdf_q;
  reg sleep_q;
  reg to_d;
  reg pdf_d;
  reg sleep_d;
  reg [`WDT_W-1:0] wdt_cnt_d;
  reg [7:0] rc_view;
  reg [7:0] st_view;
  wire key_fire;
  wire lvsel_fire;
  wire lv_fire;
  wire key_bad;
  wire lv_bad;
  wire lv_hold;
  wire wdt_ovf;
  wire full_rst;
  wire sleep_wake;
  wire wr_wdt;
  wire wr_rc;
  wire wr_lv;

  assign key_bad = !key_ok(wdt_ctrl_q[`KEY_HI:`KEY_LO]);
  assign lv_bad = !lv_ok(lv_level_q);
  // the comparator is masked in sleep, so a dip then is never counted
  assign lv_hold = lowvolt_detect_i && !sleep_q;
  assign wdt_ovf = !key_bad && tick_q &&
                   (wdt_cnt_q == term_cnt(wdt_ctrl_q[`SEL_HI:`SEL_LO]));
  assign full_rst = key_fire || lvsel_fire || lv_fire ||
                    (wdt_ovf && !sleep_q);
  assign sleep_wake = wdt_ovf && sleep_q;
  assign wr_wdt = wr_i && (addr_i == `IDX_WDT_CTRL) && !full_rst;
  assign wr_rc = wr_i && (addr_i == `IDX_RST_CTRL);
  assign wr_lv = wr_i && (addr_i == `IDX_LV_LEVEL) && !full_rst;

  // ----------------------------------------
  // delay and debounce timers
  // ----------------------------------------
  hold_timer #(
    .N(SOFT_DLY_CYC),
    .W(CNT_W)
  ) u_key_delay (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .clr_i(full_rst),
    .hold_i(key_bad),
    .fire_o(key_fire)
  );

  hold_timer #(
    .N(SOFT_DLY_CYC),
    .W(CNT_W)
  ) u_lvsel_delay (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .clr_i(full_rst),
    .hold_i(lv_bad),
    .fire_o(lvsel_fire)
  );

  hold_timer #(
    .N(LV_DEB_CYC),
    .W(CNT_W)
  ) u_lv_debounce (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .clr_i(full_rst),
    .hold_i(lv_hold),
    .fire_o(lv_fire)
  );

  // ----------------------------------------
  // slow oscillator tick
  // ----------------------------------------
  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      div_q <= {CNT_W{1'b0}};
      tick_q <= 1'b0;
    end else begin
      tick_q <= (div_q == DIV_LAST);
      if (div_q == DIV_LAST) begin
        div_q <= {CNT_W{1'b0}};
      end else begin
        div_q <= div_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ----------------------------------------
  // watchdog counter
  // ----------------------------------------
  // software only sees the clear instruction, not the count itself
  always @* begin
    wdt_cnt_d = wdt_cnt_q;
    if (full_rst || sleep_wake || wdt_ovf) begin
      wdt_cnt_d = {`WDT_W{1'b0}};
    end else if (key_bad || wdt_clear_exec_i || halt_exec_i) begin
      wdt_cnt_d = {`WDT_W{1'b0}};
    end else if (tick_q) begin
      wdt_cnt_d = wdt_cnt_q + {{(`WDT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      wdt_cnt_q <= {`WDT_W{1'b0}};
    end else begin
      wdt_cnt_q <= wdt_cnt_d;
    end
  end

  // ----------------------------------------
  // watchdog control register
  // ----------------------------------------
  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      wdt_ctrl_q <= `WDT_CTRL_RST;
    end else if (full_rst) begin
      wdt_ctrl_q <= `WDT_CTRL_RST;
    end else if (wr_wdt) begin
      wdt_ctrl_q <= wdata_i;
    end
  end

  // ----------------------------------------
  // low-voltage level register
  // ----------------------------------------
  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      lv_level_q <= `LV_LEVEL_RST;
    end else if (key_fire || lvsel_fire || (wdt_ovf && !sleep_q)) begin
      lv_level_q <= `LV_LEVEL_RST;
    end else if (lv_fire) begin
      lv_level_q <= lv_level_q;
    end else if (wr_lv) begin
      lv_level_q <= wdata_i;
    end
  end

  // ----------------------------------------
  // reset source control register
  // ----------------------------------------
  // a flag set in the same cycle as a software zero write stays set
  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      wrf_q <= 1'b0;
      lrf_q <= 1'b0;
      lowvolt_reset_flag_q <= 1'b0;
      idle_sysclk_keep_o <= 1'b0;
      fast_osc_freq_select_o <= 2'h0;
    end else begin
      if (key_fire) begin
        wrf_q <= 1'b1;
      end else if (wr_rc && !wdata_i[`RC_WRF]) begin
        wrf_q <= 1'b0;
      end
      if (lvsel_fire) begin
        lrf_q <= 1'b1;
      end else if (wr_rc && !wdata_i[`RC_LRF]) begin
        lrf_q <= 1'b0;
      end
      if (lv_fire) begin
        lowvolt_reset_flag_q <= 1'b1;
      end else if (wr_rc && !wdata_i[`RC_LOWVOLT_RESET_FLAG]) begin
        lowvolt_reset_flag_q <= 1'b0;
      end
      if (full_rst) begin
        idle_sysclk_keep_o <= 1'b0;
        fast_osc_freq_select_o <= 2'h0;
      end else if (wr_rc) begin
        idle_sysclk_keep_o <= wdata_i[`RC_SYSCLK];
        fast_osc_freq_select_o <= wdata_i[`RC_FOSC_HI:`RC_FOSC_LO];
      end
    end
  end

  // ----------------------------------------
  // status flags and sleep state
  // ----------------------------------------
  // for TO and PDF set beats clear when both land in one cycle; for sleep a wake or reset beats halt
  always @* begin
    to_d = to_q;
    pdf_d = pdf_q;
    sleep_d = sleep_q;
    if (wdt_ovf) begin
      to_d = 1'b1;
    end else if (halt_exec_i) begin
      to_d = 1'b0;
    end
    if (halt_exec_i && !full_rst) begin
      pdf_d = 1'b1;
    end else if (wdt_clear_exec_i) begin
      pdf_d = 1'b0;
    end
    if (full_rst || sleep_wake || wake_i) begin
      sleep_d = 1'b0;
    end else if (halt_exec_i) begin
      sleep_d = 1'b1;
    end
  end

  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      to_q <= 1'b0;
      pdf_q <= 1'b0;
      sleep_q <= 1'b0;
    end else begin
      to_q <= to_d;
      pdf_q <= pdf_d;
      sleep_q <= sleep_d;
    end
  end

  // ----------------------------------------
  // reset outputs
  // ----------------------------------------
  // a wake by timeout touches only program counter and stack, so
  // sys_reset_o stays low then
  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      sys_reset_o <= 1'b1;
      pc_sp_reset_o <= 1'b1;
      port_init_o <= 1'b1;
      asleep_o <= 1'b0;
      lowvolt_level_o <= `LV_LEVEL_RST;
    end else begin
      sys_reset_o <= full_rst;
      pc_sp_reset_o <= full_rst || sleep_wake;
      port_init_o <= full_rst;
      asleep_o <= sleep_q;
      lowvolt_level_o <= lv_level_q;
    end
  end

  // ----------------------------------------
  // register views
  // ----------------------------------------
  // bits 6 and 3 have no storage and stay zero
  always @* begin
    rc_view = 8'h00;
    rc_view[`RC_SYSCLK] = idle_sysclk_keep_o;
    rc_view[`RC_FOSC_HI:`RC_FOSC_LO] = fast_osc_freq_select_o;
    rc_view[`RC_LOWVOLT_RESET_FLAG] = lowvolt_reset_flag_q;
    rc_view[`RC_LRF] = lrf_q;
    rc_view[`RC_WRF] = wrf_q;
    st_view = 8'h00;
    st_view[`ST_TO] = to_q;
    st_view[`ST_PDF] = pdf_q;
  end

  // ----------------------------------------
  // register read port
  // ----------------------------------------
  always @(posedge core_clk_i) begin
    if (!resetn_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `IDX_WDT_CTRL: rdata_o <= wdt_ctrl_q;
        `IDX_RST_CTRL: rdata_o <= rc_view;
        `IDX_LV_LEVEL: rdata_o <= lv_level_q;
        `IDX_STATUS: rdata_o <= st_view;
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

endmodule // watchdog_reset_ctrl

/* testbench/watchdog_reset_ctrl_assertions.sv */
`timescale 1ns/1ps
// ----
// port checks
// ----
module wrc_chk (
  input wire core_clk_i,
  input wire resetn_i,
  input wire [1:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  input wire halt_exec_i,
  input wire sys_reset_o,
  input wire pc_sp_reset_o,
  input wire port_init_o,
  input wire asleep_o,
  input wire [7:0] lowvolt_level_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  a_rd_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not zero");
  a_ctrl_gaps: assert property ($past(rd_i) && $past(addr_i) == 2'h1
    |-> rdata_o[6] == 1'b0 && rdata_o[3] == 1'b0) else $error("gap bits set");
  a_key_reset: assert property (wr_i && addr_i == 2'h0 && wdata_i[7:3] != 5'h15
    && wdata_i[7:3] != 5'h0A |-> ##[1:20] sys_reset_o) else $error("no key reset");
  a_reset_pulse: assert property (sys_reset_o |=> !sys_reset_o)
    else $error("reset pulse too long");
  a_sleep_norst: assert property (asleep_o && $past(asleep_o) |-> !sys_reset_o)
    else $error("full reset while asleep");
  a_sleep_pcsp: assert property (pc_sp_reset_o && !sys_reset_o |-> $past(asleep_o))
    else $error("partial reset while awake");
  a_port_init: assert property (port_init_o |-> sys_reset_o)
    else $error("port init without reset");
  a_pc_zero: assert property (sys_reset_o |-> pc_sp_reset_o)
    else $error("pc not cleared on reset");
  a_halt_sleep: assert property ($rose(asleep_o) |-> $past(halt_exec_i, 2))
    else $error("sleep without halt");
  a_lv_write: assert property ($past(wr_i, 2) && $past(addr_i, 2) == 2'h2
    && !$past(sys_reset_o) |-> lowvolt_level_o == $past(wdata_i, 2))
    else $error("level write lost");
endmodule // wrc_chk

bind watchdog_reset_ctrl wrc_chk u_chk (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .halt_exec_i(halt_exec_i), .sys_reset_o(sys_reset_o), .pc_sp_reset_o(pc_sp_reset_o),
  .port_init_o(port_init_o), .asleep_o(asleep_o), .lowvolt_level_o(lowvolt_level_o));

/* testbench/test_watchdog_reset_ctrl.sv */
`timescale 1ns/1ps
// ----
// bench
// ----
module test_watchdog_reset_ctrl;
  logic clk, rstn, wr, rd, halt, clr, wake, lv, srst, pcsp, asleep, idle;
  logic [1:0] addr, fosc;
  logic [7:0] wdata, rdata, lvl;
  int bad_count = 0;
  int checks_done = 0;
  int n_sys = 0;
  int n_pc = 0;
  // short counts keep the run small; 2^8 ticks are 1024 cycles here
  watchdog_reset_ctrl #(.SLOW_DIV(4), .SOFT_DLY_CYC(4), .LV_DEB_CYC(4)) dut_u (
    .core_clk_i(clk), .resetn_i(rstn), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .halt_exec_i(halt), .wdt_clear_exec_i(clr),
    .wake_i(wake), .lowvolt_detect_i(lv), .sys_reset_o(srst), .pc_sp_reset_o(pcsp),
    .port_init_o(), .asleep_o(asleep), .lowvolt_level_o(lvl), .idle_sysclk_keep_o(idle),
    .fast_osc_freq_select_o(fosc));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // counted off the sampling edge so tasks never race the update
  always @(negedge clk) if (rstn) begin
    n_sys += srst;
    n_pc += pcsp && !srst;
  end
  task automatic complete_run;
    if (bad_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdr(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic go(input int k);
    @(posedge clk);
    {halt, clr, wake} <= 3'b100 >> k;
    @(posedge clk);
    {halt, clr, wake} <= 3'b000;
  endtask
  task automatic wt(input int lim);
    int s;
    s = n_sys + n_pc;
    repeat (lim) if (n_sys + n_pc == s) @(posedge clk);
  endtask
  task automatic t_codes;
    logic [7:0] c [4] = '{8'h55, 8'h33, 8'h99, 8'hAA};
    int s;
    s = n_sys;
    foreach (c[i]) begin
      wrr(2'h2, c[i]);
      repeat (10) @(posedge clk);
      rdr(2'h2, c[i]);
    end
    chk(8'(n_sys - s), 8'h00);
  endtask
  task automatic t_fault(input logic [1:0] a, input logic [7:0] bad, input logic [7:0] f,
                         input logic [7:0] rv);
    int s;
    s = n_sys;
    wrr(a, bad);
    wt(40);
    chk(8'(n_sys - s), 8'h01);
    rdr(2'h1, f);
    rdr(a, rv);
    wrr(2'h1, 8'hFF);
    rdr(2'h1, f | 8'hB0);
    chk({5'h00, idle, fosc}, 8'h07);
    wrr(2'h1, 8'h00);
    rdr(2'h1, 8'h00);
  endtask
  task automatic t_lv;
    int s;
    wrr(2'h2, 8'h33);
    s = n_sys;
    @(posedge clk);
    lv <= 1'b1;
    repeat (2) @(posedge clk);
    lv <= 1'b0;
    repeat (10) @(posedge clk);
    chk(8'(n_sys - s), 8'h00);
    lv <= 1'b1;
    wt(40);
    lv <= 1'b0;
    chk(8'(n_sys - s), 8'h01);
    rdr(2'h1, 8'h04);
    rdr(2'h2, 8'h33);
    chk(lvl, 8'h33);
    wrr(2'h1, 8'h00);
  endtask
  task automatic t_wdt;
    int s;
    wrr(2'h0, 8'h50);
    s = n_sys;
    repeat (3) begin
      repeat (800) @(posedge clk);
      go(1);
    end
    repeat (1000) @(posedge clk);
    chk(8'(n_sys - s), 8'h00);
    wt(60);
    chk(8'(n_sys - s), 8'h01);
    rdr(2'h3, 8'h02);
  endtask
  task automatic t_sleep;
    int s, p;
    wrr(2'h0, 8'h50);
    go(0);
    rdr(2'h3, 8'h01);
    chk({7'h00, asleep}, 8'h01);
    s = n_sys;
    p = n_pc;
    @(posedge clk);
    lv <= 1'b1;
    repeat (20) @(posedge clk);
    lv <= 1'b0;
    wt(1100);
    chk(8'(n_sys - s), 8'h00);
    chk(8'(n_pc - p), 8'h01);
    rdr(2'h3, 8'h03);
    rdr(2'h0, 8'h50);
    chk({7'h00, asleep}, 8'h00);
    go(2);
    go(1);
    rdr(2'h3, 8'h02);
    go(0);
    go(2);
    #1 chk({7'h00, asleep}, 8'h01);
    repeat (2) @(posedge clk);
    #1 chk({7'h00, asleep}, 8'h00);
    rdr(2'h3, 8'h01);
  endtask
  initial begin
    {rstn, wr, rd, halt, clr, wake, lv} = 7'h00;
    addr = 2'h0;
    wdata = 8'h00;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rdr(2'h0, 8'h53);
    rdr(2'h1, 8'h00);
    rdr(2'h2, 8'h55);
    rdr(2'h3, 8'h00);
    t_codes;
    t_fault(2'h0, 8'h03, 8'h01, 8'h53);
    t_fault(2'h2, 8'h12, 8'h02, 8'h55);
    t_lv;
    t_wdt;
    t_sleep;
    complete_run;
  end
  initial begin
    #200us;
    bad_count++;
    complete_run;
  end
endmodule // test_watchdog_reset_ctrl
